// >>> src/sdram_pin_pkg.sv
// package: constants and carrier types for the sdram control-pin front end
package sdram_pin_pkg;
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int ADDR_W = 13;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int COL_W = 9;
  localparam int SCOPE_BIT = 10;
  localparam int MASK_LAT = 2;
  localparam logic [1:0] MASK_LAT_CNT = 2'h2;
  localparam logic [3:0] BURST_LEN = 4'h4;
  localparam logic [3:0] BURST_ONE = 4'h1;
  localparam logic [BANKS-1:0] BANKS_NONE = 4'h0;
  localparam logic [BANKS-1:0] BANKS_ALL = 4'hF;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
  localparam logic [COL_W-1:0] COL_ONE = 9'h001;

  // raw {ras,cas,we} code with select low
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_BST = 3'h6;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF, OP_MRS, OP_BST, OP_DESEL
  } op_t;

  typedef enum logic [2:0] {
    PM_RUN, PM_PRE_PD, PM_ACT_PD, PM_SELF_REF, PM_SUSPEND
  } pmode_t;

  // command pins as driven by the controller
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  // mask lanes: [1] high_byte_mask, [0] low_byte_mask
  typedef struct packed {
    logic high_byte_mask;
    logic low_byte_mask;
  } mask_t;

  // one request toward the array
  typedef struct packed {
    logic wr_en;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic [LANES-1:0] lane_en;
    logic [DATA_W-1:0] data;
  } array_req_t;
endpackage

// >>> src/cmd_decode.sv
// module: combinational sdram command decoder from the select and strobe pins
`timescale 1ns/1ps
module cmd_decode
(
  input wire sdram_pin_pkg::cmd_pins_t i_pins,
  output sdram_pin_pkg::op_t o_op
);
  import sdram_pin_pkg::*;

  wire [2:0] code = {i_pins.ras_n, i_pins.cas_n, i_pins.we_n};

  // select high masks every command
  always_comb
  begin
    if (i_pins.cs_n) o_op = OP_DESEL;
    else
    begin
      case (code)
        CMD_ACT: o_op = OP_ACT;
        CMD_RD: o_op = OP_RD;
        CMD_WR: o_op = OP_WR;
        CMD_PRE: o_op = OP_PRE;
        CMD_REF: o_op = OP_REF;
        CMD_MRS: o_op = OP_MRS;
        CMD_BST: o_op = OP_BST;
        default: o_op = OP_NOP;
      endcase
    end
  end
endmodule

// >>> src/sdram_pin_front.sv
// module: sdram control-pin front end with power modes, bursts and byte masks
`timescale 1ns/1ps
module sdram_pin_front
#(
  parameter int DATA_W = sdram_pin_pkg::DATA_W,
  parameter bit SINGLE_MASK = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cke,
  input wire sdram_pin_pkg::cmd_pins_t i_pins,
  input wire sdram_pin_pkg::mask_t i_mask,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic [DATA_W-1:0] i_rd_data,
  output sdram_pin_pkg::array_req_t o_req,
  output logic o_req_valid,
  output logic [DATA_W-1:0] o_dq,
  output logic [DATA_W-1:0] o_dq_oe,
  output sdram_pin_pkg::pmode_t o_pmode,
  output logic o_rx_enable,
  output logic [sdram_pin_pkg::BANKS-1:0] o_open_banks,
  output logic [sdram_pin_pkg::ADDR_W-1:0] o_mode_word
);
  import sdram_pin_pkg::*;

  cmd_pins_t pins_q;
  mask_t mask_q;
  logic cke_q;
  logic [DATA_W-1:0] dq_q;
  op_t op;
  pmode_t pmode;
  logic [BANKS-1:0] open_banks;
  logic [3:0] burst_left;
  logic burst_wr;
  logic [BANK_W-1:0] burst_bank;
  logic [COL_W-1:0] burst_col;
  logic [LANES-1:0] rd_pipe1;
  logic rd_pipe1_v;

  // lane mask: narrow parts use the upper pin for every lane
  function automatic logic [LANES-1:0] lane_mask(input mask_t m, input bit single);
    lane_mask = single ? {LANES{m.high_byte_mask}} : {m.high_byte_mask, m.low_byte_mask};
  endfunction

  function automatic logic [DATA_W-1:0] lane_expand(input logic [LANES-1:0] l);
    lane_expand = {{LANE_W{l[1]}}, {LANE_W{l[0]}}};
  endfunction

  // input capture; receivers frozen in power-down and self refresh, still live while suspended
  wire rx_on = (pmode != PM_PRE_PD) && (pmode != PM_ACT_PD) && (pmode != PM_SELF_REF);
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pins_q <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      mask_q <= '0;
      dq_q <= '0;
    end
    else if (rx_on)
    begin
      pins_q <= i_pins;
      mask_q <= i_mask;
      dq_q <= i_dq;
    end
  end

  // cke is sampled every edge: in low-power modes it acts as a level wake
  always_ff @(posedge i_clk)
  begin
    if (i_rst) cke_q <= 1'b1;
    else cke_q <= i_cke;
  end

  cmd_decode u_dec
  (
    .i_pins(pins_q),
    .o_op(op)
  );

  wire clk_active = cke_q;
  wire in_burst = burst_left != 4'h0;
  wire run = pmode == PM_RUN;
  wire take = run && clk_active;
  wire [LANES-1:0] lanes_now = lane_mask(mask_q, SINGLE_MASK);
  wire pre_all = pins_q.addr[SCOPE_BIT];
  wire [BANKS-1:0] bank_bit = BANKS'(1) << pins_q.bank_select;

  // power mode selection from the gate and current bank state
  pmode_t next_pmode;
  always_comb
  begin
    next_pmode = pmode;
    case (pmode)
      PM_RUN:
        if (!clk_active)
        begin
          if (in_burst) next_pmode = PM_SUSPEND;
          else if (op == OP_REF && open_banks == BANKS_NONE) next_pmode = PM_SELF_REF;
          else if (open_banks == BANKS_NONE) next_pmode = PM_PRE_PD;
          else next_pmode = PM_ACT_PD;
        end
      PM_SUSPEND, PM_PRE_PD, PM_ACT_PD, PM_SELF_REF:
        if (clk_active) next_pmode = PM_RUN;
      default: next_pmode = PM_RUN;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst) pmode <= PM_RUN;
    else pmode <= next_pmode;
  end

  // bank bookkeeping and mode word; deselect leaves op as DESEL so nothing changes
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      open_banks <= BANKS_NONE;
      o_mode_word <= MODE_RESET;
    end
    else if (take)
    begin
      if (op == OP_ACT) open_banks <= open_banks | bank_bit;
      if (op == OP_PRE) open_banks <= pre_all ? BANKS_NONE : (open_banks & ~bank_bit);
      if (op == OP_MRS) o_mode_word <= pins_q.addr;
    end
  end

  // burst engine: runs on through deselect, frozen while suspended
  wire start = take && (op == OP_RD || op == OP_WR);
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      burst_left <= 4'h0;
      burst_wr <= 1'b0;
      burst_bank <= '0;
      burst_col <= '0;
    end
    else if (start)
    begin
      // the start beat already serves the first column, so only the rest stay counted
      burst_left <= BURST_LEN - BURST_ONE;
      burst_wr <= op == OP_WR;
      burst_bank <= pins_q.bank_select;
      burst_col <= pins_q.addr[COL_W-1:0] + COL_ONE;
    end
    else if (take && op == OP_BST) burst_left <= 4'h0;
    else if (take && in_burst)
    begin
      burst_left <= burst_left - BURST_ONE;
      burst_col <= burst_col + COL_ONE;
    end
  end

  // array request; write mask drops lanes so they stay unchanged
  wire beat = take && (start || (in_burst && op != OP_BST));
  wire beat_wr = start ? (op == OP_WR) : burst_wr;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_req <= '0;
      o_req_valid <= 1'b0;
    end
    else
    begin
      o_req_valid <= beat;
      o_req.wr_en <= beat_wr;
      o_req.bank <= start ? pins_q.bank_select : burst_bank;
      o_req.col <= start ? pins_q.addr[COL_W-1:0] : burst_col;
      o_req.lane_en <= ~lanes_now;
      o_req.data <= dq_q;
    end
  end

  // read output pipe: the drive enables follow two edges after the mask capture edge,
  // so one stage, rd_pipe1, sits between mask_q and the drive enables
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_pipe1 <= '0;
      rd_pipe1_v <= 1'b0;
      o_dq <= '0;
      o_dq_oe <= '0;
    end
    else if (pmode != PM_SUSPEND && clk_active)
    begin
      rd_pipe1_v <= beat && !beat_wr;
      rd_pipe1 <= lanes_now;
      o_dq <= i_rd_data;
      o_dq_oe <= lane_expand({LANES{rd_pipe1_v}} & ~rd_pipe1);
    end
  end

  // mode and receiver status outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pmode <= PM_RUN;
      o_rx_enable <= 1'b1;
      o_open_banks <= BANKS_NONE;
    end
    else
    begin
      o_pmode <= next_pmode;
      o_rx_enable <= next_pmode == PM_RUN || next_pmode == PM_SUSPEND;
      o_open_banks <= open_banks;
    end
  end

  a_desel_no_bank: assert property (@(posedge i_clk) disable iff (i_rst)
    pins_q.cs_n && pmode == PM_RUN |=> $stable(open_banks))
    else $error("bank state changed under deselect");
  a_suspend_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
    pmode == PM_SUSPEND && !cke_q |=> $stable(burst_left))
    else $error("burst moved while suspended");
  a_pd_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    pmode == PM_RUN && !cke_q && !in_burst && open_banks == BANKS_NONE
    && op != OP_REF |=> pmode == PM_PRE_PD)
    else $error("missed precharge power-down");
  a_act_pd: assert property (@(posedge i_clk) disable iff (i_rst)
    pmode == PM_RUN && !cke_q && !in_burst && open_banks != BANKS_NONE
    |=> pmode == PM_ACT_PD)
    else $error("missed active power-down");
  a_rx_frozen: assert property (@(posedge i_clk) disable iff (i_rst)
    pmode == PM_SELF_REF |=> $stable(pins_q))
    else $error("inputs captured in self refresh");
  a_wake_run: assert property (@(posedge i_clk) disable iff (i_rst)
    pmode != PM_RUN && cke_q |=> pmode == PM_RUN)
    else $error("no wake on gate high");
  a_wr_mask: assert property (@(posedge i_clk) disable iff (i_rst)
    beat && beat_wr |=> o_req_valid && o_req.lane_en == ~$past(lanes_now))
    else $error("write mask not applied");
  a_pre_all: assert property (@(posedge i_clk) disable iff (i_rst)
    take && op == OP_PRE && pre_all |=> open_banks == BANKS_NONE)
    else $error("precharge all left a bank open");
  a_burst_step: assert property (@(posedge i_clk) disable iff (i_rst)
    take && in_burst && !start && op != OP_BST |=> burst_left == $past(burst_left) - 4'h1)
    else $error("burst counter did not step");
endmodule

// >>> dv/sdram_ctrl_model.sv
// controller-side model that drives the sdram command, mask and data pins
`timescale 1ns/1ps
module sdram_ctrl_model
(
  input wire logic i_clk,
  output logic o_cke,
  output sdram_pin_pkg::cmd_pins_t o_pins,
  output sdram_pin_pkg::mask_t o_mask,
  output logic [sdram_pin_pkg::DATA_W-1:0] o_dq
);
  import sdram_pin_pkg::*;
  // idle is deselected with all strobes high
  initial
  begin
    o_cke = 1'b1;
    o_pins = {1'b1, 3'h7, 2'h0, 13'h0000};
    o_mask = 2'h0;
    o_dq = 16'hA55A;
  end
  // one command beat, held a whole cycle, then address inverted so nothing stale looks held
  task automatic issue(input logic [2:0] code, input logic [1:0] bank,
                       input logic [12:0] addr, input logic cs_n);
    @(negedge i_clk);
    o_pins = {cs_n, code, bank, addr};
    @(negedge i_clk);
    o_pins = {1'b1, 3'h7, ~bank, ~addr};
  endtask
  task automatic set_cke(input logic v);
    @(negedge i_clk);
    o_cke = v;
  endtask
  // refresh with the gate dropped in the same cycle asks for self refresh
  task automatic refresh_sleep;
    @(negedge i_clk);
    o_pins = {1'b0, CMD_REF, 2'h0, 13'h0000};
    o_cke = 1'b0;
    @(negedge i_clk);
    o_pins = {1'b1, 3'h7, 2'h3, 13'h1FFF};
  endtask
endmodule

// >>> dv/tb_sdram_control_pin_interface.sv
// self-checking bench for the sdram control-pin front end
`timescale 1ns/1ps
module tb_sdram_control_pin_interface;
  import sdram_pin_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [DATA_W-1:0] i_rd_data = 16'h0000;
  logic cke;
  cmd_pins_t pins;
  mask_t mask;
  logic [DATA_W-1:0] dq;
  logic [DATA_W-1:0] o_dq;
  logic [DATA_W-1:0] o_dq_oe;
  array_req_t o_req;
  logic o_req_valid;
  logic o_rx_enable;
  pmode_t o_pmode;
  logic [BANKS-1:0] o_open_banks;
  logic [ADDR_W-1:0] o_mode_word;
  int err_count = 0;
  int compares = 0;
  always #5 i_clk = ~i_clk;
  // array feedback changes every cycle so a stuck output stage shows
  always @(negedge i_clk) i_rd_data <= i_rd_data + 16'h1111;
  sdram_ctrl_model ctrl (.i_clk(i_clk), .o_cke(cke), .o_pins(pins), .o_mask(mask), .o_dq(dq));
  sdram_pin_front dut (.i_clk(i_clk), .i_rst(i_rst), .i_cke(cke), .i_pins(pins),
    .i_mask(mask), .i_dq(dq), .i_rd_data(i_rd_data), .o_req(o_req),
    .o_req_valid(o_req_valid), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_pmode(o_pmode),
    .o_rx_enable(o_rx_enable), .o_open_banks(o_open_banks), .o_mode_word(o_mode_word));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // bounded waits; an exhausted bound in wait_valid ends the run, in wait_pm it only counts a mismatch
  task automatic wait_valid;
    int k;
    for (k = 0; k < 8 && o_req_valid !== 1'b1; k++)
      @(negedge i_clk);
    if (k == 8)
    begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic wait_pm(input pmode_t p);
    int k;
    for (k = 0; k < 8 && o_pmode !== p; k++)
      @(negedge i_clk);
    chk("pmode", p, o_pmode);
  endtask
  task automatic t_reset;
    chk("pmode", PM_RUN, o_pmode);
    chk("rx_enable", 1, o_rx_enable);
    chk("open_banks", 0, o_open_banks);
    chk("req_valid", 0, o_req_valid);
    chk("dq_oe", 0, o_dq_oe);
  endtask
  task automatic t_mode_and_act;
    ctrl.issue(CMD_MRS, 2'h0, 13'h0123, 1'b0);
    @(negedge i_clk);
    chk("mode_word", 13'h0123, o_mode_word);
    ctrl.issue(CMD_ACT, 2'h1, 13'h0000, 1'b1);
    @(negedge i_clk);
    @(negedge i_clk);
    chk("open_banks", 0, o_open_banks);
    ctrl.issue(CMD_ACT, 2'h2, 13'h0055, 1'b0);
    @(negedge i_clk);
    @(negedge i_clk);
    chk("open_banks", 4'h4, o_open_banks);
  endtask
  // four-beat burst to bank 2; select stays high meanwhile, masks held throughout
  task automatic burst(input logic [2:0] code, input logic [8:0] col, input logic [1:0] m,
                       input logic [1:0] lanes, input logic [15:0] oe);
    int b;
    ctrl.o_mask = m;
    ctrl.issue(code, 2'h2, {4'h0, col}, 1'b0);
    wait_valid();
    for (b = 0; b < 4; b++)
    begin
      if (b > 0)
        @(negedge i_clk);
      chk("req_valid", 1, o_req_valid);
      chk("req_wr_en", code == CMD_WR, o_req.wr_en);
      chk("req_bank", 2, o_req.bank);
      chk("req_col", col + b, o_req.col);
      chk("req_lane_en", lanes, o_req.lane_en);
      chk("req_data", 16'hA55A, o_req.data);
      chk("dq", i_rd_data, o_dq);
      if (b > 0)
        chk("dq_oe", oe, o_dq_oe);
    end
    @(negedge i_clk);
    chk("req_valid", 0, o_req_valid);
  endtask
  // read burst frozen by the gate after three beats, then finished after wake
  task automatic t_suspend;
    ctrl.o_mask = 2'h0;
    ctrl.issue(CMD_RD, 2'h2, 13'h0040, 1'b0);
    wait_valid();
    chk("req_col", 9'h040, o_req.col);
    ctrl.set_cke(1'b0);
    wait_pm(PM_SUSPEND);
    chk("req_valid", 0, o_req_valid);
    chk("rx_enable", 1, o_rx_enable);
    ctrl.set_cke(1'b1);
    wait_pm(PM_RUN);
    wait_valid();
    chk("req_col", 9'h043, o_req.col);
    @(negedge i_clk);
    chk("req_valid", 0, o_req_valid);
  endtask
  // burst stop cuts a read burst before its last beat
  task automatic t_stop;
    ctrl.issue(CMD_RD, 2'h2, 13'h0080, 1'b0);
    wait_valid();
    ctrl.issue(CMD_BST, 2'h2, 13'h0000, 1'b0);
    @(negedge i_clk);
    chk("req_valid", 0, o_req_valid);
  endtask
  task automatic t_power;
    ctrl.set_cke(1'b0);
    wait_pm(PM_ACT_PD);
    chk("rx_enable", 0, o_rx_enable);
    ctrl.set_cke(1'b1);
    wait_pm(PM_RUN);
    chk("rx_enable", 1, o_rx_enable);
    ctrl.issue(CMD_PRE, 2'h0, 13'h0400, 1'b0);
    @(negedge i_clk);
    @(negedge i_clk);
    chk("open_banks", 0, o_open_banks);
    ctrl.set_cke(1'b0);
    wait_pm(PM_PRE_PD);
    ctrl.set_cke(1'b1);
    wait_pm(PM_RUN);
    ctrl.refresh_sleep();
    wait_pm(PM_SELF_REF);
    chk("rx_enable", 0, o_rx_enable);
    ctrl.set_cke(1'b1);
    wait_pm(PM_RUN);
    chk("rx_enable", 1, o_rx_enable);
  endtask
  initial
  begin
    repeat (10) @(negedge i_clk);
    t_reset();
    i_rst = 1'b0;
    t_mode_and_act();
    burst(CMD_WR, 9'h010, 2'h1, 2'h2, 16'h0000);
    burst(CMD_RD, 9'h1FC, 2'h2, 2'h1, 16'h00FF);
    t_suspend();
    t_stop();
    t_power();
    end_of_test();
  end
endmodule
